/* core/wps_core.sv */
// module: watchdog, light/deep sleep sequencing and configuration word reads
`timescale 1ns/100ps
module wps_core #(
  parameter int WDT_W = 16
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst_b,
  input  wire logic                            external_pin_reset_b,
  input  wire logic                            poweron_reset_req,
  input  wire logic                            brownout_reset_req,
  input  wire logic                            low_power_rc_clock,
  input  wire logic                            watchdog_clear_instruction,
  input  wire logic                            power_save_instruction,
  input  wire logic                            power_save_operand,
  input  wire logic                            irq_wake,
  input  wire logic [1:0]                      current_osc_source,
  input  wire logic                            low_power_crystal_keep,
  input  wire logic                            oscillator_startup_timer_done,
  input  wire logic                            pll_lock_flag,
  input  wire logic                            lvd_enable,
  input  wire logic                            nv_erased,
  input  wire logic [wps_pkg::CFG_DATA_W-1:0]  osc_cfg_fuses,
  input  wire logic [wps_pkg::CFG_DATA_W-1:0]  wdt_cfg_fuses,
  input  wire logic [wps_pkg::CFG_DATA_W-1:0]  brn_cfg_fuses,
  input  wire logic [wps_pkg::CFG_DATA_W-1:0]  prot_cfg_fuses,
  input  wire logic                            tbl_rd,
  input  wire logic [23:0]                     tbl_addr,
  output logic      [wps_pkg::CFG_WORD_W-1:0]  tbl_rdata,
  input  wire logic                            sfr_wr,
  input  wire logic                            sfr_rd,
  input  wire logic [15:0]                     sfr_addr,
  input  wire logic [15:0]                     sfr_wdata,
  output logic      [15:0]                     sfr_rdata,
  output logic                                 cpu_clk_en,
  output logic                                 periph_clk_en,
  output logic                                 osc_en,
  output logic                                 clk_mon_active,
  output logic                                 low_power_rc_clock_en,
  output logic                                 brownout_active,
  output logic                                 lvd_active,
  output logic [1:0]                           active_osc_source,
  output logic                                 sys_reset,
  output logic                                 wake_pulse,
  output logic                                 wake_to_isr,
  output logic                                 clk_fail_trap,
  output wps_pkg::wps_state_t                  power_state
);
  import wps_pkg::*;

  logic [1:0]       pin_sync_reg;
  logic [1:0]       low_power_rc_clock_sync_reg;
  logic             low_power_rc_clock_prev_reg;
  logic [WDT_W-1:0] wdt_cnt_reg;
  logic [15:0]      rc_reg;
  logic [15:0]      rc_next;
  wps_state_t       state_reg;
  wps_state_t       state_next;
  logic [1:0]       src_reg;
  logic [DLY_W-1:0] tgt_reg;
  logic [DLY_W-1:0] dly_reg;
  logic             xtal_reg;
  logic             pll_reg;
  logic             irq_cause_reg;
  logic [15:0]      osc_word;
  logic [15:0]      wdt_word;
  logic [15:0]      brn_word;
  logic [15:0]      prot_word;
  logic             watchdog_fuse_enable;
  logic [1:0]       oscillator_source_fuses;
  logic [3:0]       primary_oscillator_mode_fuses;
  logic             clock_failure_monitor;
  logic             clk_sw_en;
  logic [1:0]       wake_src;
  logic             pin_rst;
  logic             low_power_rc_clock_tick;
  logic             wdt_run;
  logic             wdt_ovf;
  logic             wdt_rst;
  logic             ext_rst;
  logic             rst_evt;
  logic             osc_ready;
  logic             to_run;

  // wake delay in cycles for a given source
  function automatic logic [DLY_W-1:0] wake_delay(input logic [1:0] src, input logic [3:0] mode,
                                                  input logic keep);
    logic [DLY_W-1:0] d;
    d = DLY_W'(POWER_ON_DELAY_CYC);
    if (src == OSC_PRIMARY && mode[PRI_XTAL_BIT]) begin
      d = DLY_W'(POWER_ON_DELAY_CYC + POWERUP_TIMER_CYC);
      if (mode[PRI_PLL_BIT]) begin
        d = DLY_W'(POWER_ON_DELAY_CYC + POWERUP_TIMER_CYC + PLL_LOCK_CYC);
      end
    end else if (src == OSC_LOWPWR_XTAL && !keep) begin
      d = DLY_W'(POWER_ON_DELAY_CYC + POWERUP_TIMER_CYC);
    end
    return d;
  endfunction

  // true when the source is a crystal that needs its start-up timer
  function automatic logic needs_xtal(input logic [1:0] src, input logic [3:0] mode, input logic keep);
    return (src == OSC_PRIMARY && mode[PRI_XTAL_BIT]) || (src == OSC_LOWPWR_XTAL && !keep);
  endfunction

  // synchronisers for the reset pin and the slow RC clock
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_sync_reg <= 2'h0;
      low_power_rc_clock_sync_reg <= 2'h0;
      low_power_rc_clock_prev_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], ~external_pin_reset_b};
      low_power_rc_clock_sync_reg <= {low_power_rc_clock_sync_reg[0], low_power_rc_clock};
      low_power_rc_clock_prev_reg <= low_power_rc_clock_sync_reg[1];
    end
  end

  // effective configuration words; erased parts read all ones
  assign osc_word = nv_erased ? CFG_ERASED : osc_cfg_fuses;
  assign wdt_word = nv_erased ? CFG_ERASED : wdt_cfg_fuses;
  assign brn_word = nv_erased ? CFG_ERASED : brn_cfg_fuses;
  assign prot_word = nv_erased ? CFG_ERASED : prot_cfg_fuses;
  assign watchdog_fuse_enable = wdt_word[WDT_FUSE_EN_BIT];
  assign oscillator_source_fuses = osc_word[OSC_SRC_LSB +: 2];
  assign primary_oscillator_mode_fuses = osc_word[3:0];
  assign clock_failure_monitor = osc_word[CLK_MON_EN_BIT];
  assign clk_sw_en = osc_word[CLK_SW_EN_BIT];

  // event decode
  assign pin_rst = pin_sync_reg[1];
  assign low_power_rc_clock_tick = low_power_rc_clock_sync_reg[1] & ~low_power_rc_clock_prev_reg;
  assign wdt_run = watchdog_fuse_enable | rc_reg[RC_SW_WDT_EN];
  assign wdt_ovf = wdt_run & low_power_rc_clock_tick & (&wdt_cnt_reg) & ~watchdog_clear_instruction;
  assign wdt_rst = wdt_ovf & (state_reg != ST_SLEEP) & (state_reg != ST_IDLE);
  assign ext_rst = poweron_reset_req | brownout_reset_req | pin_rst;
  assign rst_evt = ext_rst | wdt_rst;
  assign osc_ready = !xtal_reg || (oscillator_startup_timer_done && (!pll_reg || pll_lock_flag));
  assign wake_src = clk_sw_en ? current_osc_source : oscillator_source_fuses;

  // watchdog counter on slow RC edges; clear beats increment
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wdt_cnt_reg <= '0;
    end else if (watchdog_clear_instruction || rst_evt) begin
      wdt_cnt_reg <= '0;
    end else if (wdt_run && low_power_rc_clock_tick) begin
      wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
    end
  end

  // power state transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (power_save_instruction) begin
          state_next = (power_save_operand == PS_IDLE) ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_IDLE: begin
        if (wdt_ovf || irq_wake) begin
          state_next = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wdt_ovf || irq_wake) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (dly_reg >= tgt_reg) begin
          state_next = (osc_ready || clock_failure_monitor) ? ST_RUN : ST_STALL;
        end
      end
      ST_STALL: begin
        if (osc_ready) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
    if (rst_evt) begin
      state_next = ST_RUN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // wake source, delay target and clock-failure switch
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      src_reg <= OSC_SLOW_RC;
      tgt_reg <= '0;
      xtal_reg <= 1'b0;
      pll_reg <= 1'b0;
      irq_cause_reg <= 1'b0;
    end else if (poweron_reset_req || brownout_reset_req) begin
      src_reg <= oscillator_source_fuses;
      xtal_reg <= 1'b0;
    end else if (state_reg == ST_SLEEP && state_next == ST_WAKE) begin
      src_reg <= wake_src;
      tgt_reg <= wake_delay(wake_src, primary_oscillator_mode_fuses, low_power_crystal_keep);
      xtal_reg <= needs_xtal(wake_src, primary_oscillator_mode_fuses, low_power_crystal_keep);
      pll_reg <= (wake_src == OSC_PRIMARY) && primary_oscillator_mode_fuses[PRI_PLL_BIT];
      irq_cause_reg <= irq_wake && !wdt_ovf;
    end else if (state_reg == ST_WAKE && state_next == ST_RUN && !osc_ready) begin
      src_reg <= OSC_FAST_RC;
      xtal_reg <= 1'b0;
    end else if (state_reg == ST_RUN) begin
      src_reg <= current_osc_source;
    end
  end

  // wake delay counter, only runs while waking
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dly_reg <= '0;
    end else if (state_reg == ST_WAKE && dly_reg < tgt_reg) begin
      dly_reg <= dly_reg + 1'b1;
    end else if (state_reg != ST_WAKE) begin
      dly_reg <= '0;
    end
  end

  assign to_run = (state_next == ST_RUN) && (state_reg != ST_RUN) && !rst_evt;

  // registered event outputs; one cycle each except sys_reset, which stays high while rst_evt is held
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sys_reset <= 1'b0;
      wake_pulse <= 1'b0;
      wake_to_isr <= 1'b0;
      clk_fail_trap <= 1'b0;
    end else begin
      sys_reset <= rst_evt;
      wake_pulse <= to_run;
      wake_to_isr <= to_run && ((state_reg == ST_IDLE) ? irq_wake : irq_cause_reg);
      clk_fail_trap <= (state_reg == ST_WAKE) && (state_next == ST_RUN) && !osc_ready && !rst_evt;
    end
  end

  // reset control register: software write first, hardware sets win
  always_comb begin
    rc_next = rc_reg;
    if (sfr_wr && sfr_addr == RSTCTL_ADDR) begin
      rc_next = sfr_wdata & RC_WRITE_MASK;
    end
    if (poweron_reset_req) begin
      rc_next = RC_RESET_VAL;
    end else begin
      if (brownout_reset_req) begin
        rc_next[RC_POWERON] = 1'b0;
        rc_next[RC_BROWNOUT] = 1'b1;
      end
      if (pin_rst) begin
        rc_next[RC_PIN_RESET] = 1'b1;
        rc_next[RC_SW_RESET] = 1'b0;
        rc_next[RC_WDT_TIMEOUT] = 1'b0;
        rc_next[RC_IDLE] = rc_next[RC_IDLE] & sys_reset; // a held pin keeps the state it caught
        rc_next[RC_SLEEP] = rc_next[RC_SLEEP] & sys_reset;
      end
      if (wdt_rst) begin
        rc_next[RC_WDT_TIMEOUT] = 1'b1;
        rc_next[RC_PIN_RESET] = 1'b0;
        rc_next[RC_SW_RESET] = 1'b0;
        rc_next[RC_IDLE] = 1'b0;
        rc_next[RC_SLEEP] = 1'b0;
      end
      if (ext_rst && state_reg == ST_SLEEP) begin
        rc_next[RC_SLEEP] = 1'b1;
      end
      if (ext_rst && state_reg == ST_IDLE) begin
        rc_next[RC_IDLE] = 1'b1;
      end
      if (rst_evt) begin
        rc_next[RC_SW_WDT_EN] = 1'b0;
      end
      if (!ext_rst && state_reg == ST_SLEEP && (wdt_ovf || irq_wake)) begin
        rc_next[RC_SLEEP] = 1'b1;
        rc_next[RC_WDT_TIMEOUT] = rc_next[RC_WDT_TIMEOUT] | wdt_ovf;
      end
      if (!ext_rst && state_reg == ST_IDLE && (wdt_ovf || irq_wake)) begin
        rc_next[RC_IDLE] = 1'b1;
        rc_next[RC_WDT_TIMEOUT] = rc_next[RC_WDT_TIMEOUT] | wdt_ovf;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rc_reg <= RC_RESET_VAL;
    end else begin
      rc_reg <= rc_next;
    end
  end

  // register and configuration word reads, answered next cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sfr_rdata <= 16'h0000;
      tbl_rdata <= 24'h000000;
    end else begin
      if (sfr_rd) begin
        sfr_rdata <= (sfr_addr == RSTCTL_ADDR) ? rc_reg : 16'h0000;
      end
      if (tbl_rd) begin
        case (tbl_addr)
          OSC_CFG_ADDR: tbl_rdata <= {8'h00, osc_word};
          WDT_CFG_ADDR: tbl_rdata <= {8'h00, wdt_word};
          BRN_CFG_ADDR: tbl_rdata <= {8'h00, brn_word};
          PROT_CFG_ADDR: tbl_rdata <= {8'h00, prot_word};
          default: tbl_rdata <= 24'h000000;
        endcase
      end
    end
  end

  // clock gates and oscillator enables from the power state; brownout and lvd enables ignore it
  assign cpu_clk_en = (state_reg == ST_RUN);
  assign periph_clk_en = (state_reg == ST_RUN) || (state_reg == ST_IDLE);
  assign osc_en = (state_reg != ST_SLEEP) || (src_reg == OSC_LOWPWR_XTAL && low_power_crystal_keep);
  assign clk_mon_active = clock_failure_monitor && (state_reg != ST_SLEEP);
  assign low_power_rc_clock_en = (state_reg == ST_SLEEP) ? wdt_run : (wdt_run || clock_failure_monitor);
  assign brownout_active = brn_word[BRN_EN_BIT];
  assign lvd_active = lvd_enable;
  assign active_osc_source = src_reg;
  assign power_state = state_reg;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  fuse_enable_a: assert property (watchdog_fuse_enable |-> wdt_run)
    else $error("fuse enable did not run watchdog");
  erased_read_a: assert property (nv_erased && tbl_rd && tbl_addr == WDT_CFG_ADDR
    |=> tbl_rdata[WDT_FUSE_EN_BIT])
    else $error("erased watchdog word not one");
  wdt_reset_a: assert property (wdt_ovf && state_reg == ST_RUN |=> sys_reset && rc_reg[RC_WDT_TIMEOUT])
    else $error("overflow did not reset");
  wdt_clear_a: assert property (watchdog_clear_instruction |=> wdt_cnt_reg == '0)
    else $error("clear did not zero count");
  sleep_wdt_wake_a: assert property (state_reg == ST_SLEEP && wdt_ovf && !ext_rst
    |=> !sys_reset && rc_reg[RC_SLEEP] && rc_reg[RC_WDT_TIMEOUT] && state_reg == ST_WAKE)
    else $error("sleep overflow wake wrong");
  sw_enable_a: assert property (!watchdog_fuse_enable |-> wdt_run == rc_reg[RC_SW_WDT_EN])
    else $error("software enable ignored");
  sleep_gate_a: assert property (state_reg == ST_SLEEP |-> !cpu_clk_en && !periph_clk_en && !clk_mon_active)
    else $error("clocks running in sleep");
  idle_gate_a: assert property (state_reg == ST_IDLE |-> !cpu_clk_en && periph_clk_en && osc_en)
    else $error("idle gating wrong");
  wake_delay_a: assert property (state_reg == ST_WAKE && state_next != ST_WAKE && !rst_evt
    |-> dly_reg >= tgt_reg && dly_reg >= DLY_W'(POWER_ON_DELAY_CYC))
    else $error("wake left before delay");
  fast_wake_a: assert property (state_reg == ST_SLEEP && irq_wake && !ext_rst && !wdt_ovf
    && wake_src == OSC_FAST_RC |=> state_reg == ST_WAKE ##250 state_reg == ST_WAKE ##1 state_reg == ST_RUN)
    else $error("fast RC wake delay wrong");
  idle_wake_a: assert property (state_reg == ST_IDLE && irq_wake && !rst_evt |=> cpu_clk_en && wake_to_isr)
    else $error("idle wake not immediate");
  por_flags_a: assert property (poweron_reset_req
    |=> rc_reg[RC_POWERON] && !rc_reg[RC_SLEEP] && !rc_reg[RC_IDLE])
    else $error("power-on flags wrong");
  reset_run_a: assert property (rst_evt |=> state_reg == ST_RUN && cpu_clk_en)
    else $error("reset left power saving");

  sleep_irq_c: cover property (state_reg == ST_SLEEP && irq_wake ##[1:300] wake_to_isr);
  idle_wdt_c: cover property (state_reg == ST_IDLE && wdt_ovf);
  trap_c: cover property (clk_fail_trap);
  stall_c: cover property (state_reg == ST_STALL ##1 state_reg == ST_RUN);
endmodule

/* include/wps_pkg.sv */
// package: constants and types of the watchdog and power-save controller
package wps_pkg;
  // configuration word addresses in table-read space
  localparam logic [23:0] OSC_CFG_ADDR = 24'hF80000;
  localparam logic [23:0] WDT_CFG_ADDR = 24'hF80002;
  localparam logic [23:0] BRN_CFG_ADDR = 24'hF80004;
  localparam logic [23:0] PROT_CFG_ADDR = 24'hF8000A;
  localparam int          CFG_WORD_W = 24;
  localparam int          CFG_DATA_W = 16;
  localparam logic [15:0] CFG_ERASED = 16'hFFFF;
  // reset control register address and fields
  localparam logic [15:0] RSTCTL_ADDR = 16'h0740;
  localparam int          RC_POWERON = 0;
  localparam int          RC_BROWNOUT = 1;
  localparam int          RC_IDLE = 2;
  localparam int          RC_SLEEP = 3;
  localparam int          RC_WDT_TIMEOUT = 4;
  localparam int          RC_SW_WDT_EN = 5;
  localparam int          RC_SW_RESET = 6;
  localparam int          RC_PIN_RESET = 7;
  localparam logic [15:0] RC_WRITE_MASK = 16'h00FF;
  localparam logic [15:0] RC_RESET_VAL = 16'h0003;
  // configuration word field positions
  localparam int          WDT_FUSE_EN_BIT = 15;
  localparam int          OSC_SRC_LSB = 8;
  localparam int          CLK_MON_EN_BIT = 14;
  localparam int          CLK_SW_EN_BIT = 15;
  localparam int          PRI_XTAL_BIT = 2;
  localparam int          PRI_PLL_BIT = 3;
  localparam int          BRN_EN_BIT = 7;
  // oscillator source codes
  localparam logic [1:0]  OSC_SLOW_RC = 2'h0;
  localparam logic [1:0]  OSC_FAST_RC = 2'h1;
  localparam logic [1:0]  OSC_LOWPWR_XTAL = 2'h2;
  localparam logic [1:0]  OSC_PRIMARY = 2'h3;
  // power-save instruction operand
  localparam logic        PS_SLEEP = 1'b0;
  localparam logic        PS_IDLE = 1'b1;
  // wake-up delays
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          POWER_ON_DELAY_NS = 10000;
  localparam int          POWERUP_TIMER_DELAY_NS = 64000;
  localparam int          PLL_LOCK_DELAY_NS = 20000;
  localparam int          DLY_W = 12;
  localparam int          POWER_ON_DELAY_CYC = (POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          POWERUP_TIMER_CYC = (POWERUP_TIMER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PLL_LOCK_CYC = (PLL_LOCK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power state
  typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_SLEEP, ST_WAKE, ST_STALL} wps_state_t;
endpackage

/* sim/wps_cpu_model.sv */
// processor core model issuing power-save and watchdog-clear instructions
`timescale 1ns/100ps
module wps_cpu_model (
  input  wire logic core_clk,
  output logic      watchdog_clear_instruction,
  output logic      power_save_instruction,
  output logic      power_save_operand
);
  import wps_pkg::*;
  // idle levels at time zero
  initial begin
    watchdog_clear_instruction = 1'b0;
    power_save_instruction = 1'b0;
    power_save_operand = 1'b1;
  end
  // one-cycle power-save instruction; operand is inverted once it retires
  task automatic exec_save(input logic op);
    @(posedge core_clk);
    power_save_instruction <= 1'b1;
    power_save_operand <= op;
    @(posedge core_clk);
    power_save_instruction <= 1'b0;
    power_save_operand <= ~op;
  endtask
  // one-cycle watchdog clear instruction
  task automatic exec_clear();
    @(posedge core_clk);
    watchdog_clear_instruction <= 1'b1;
    @(posedge core_clk);
    watchdog_clear_instruction <= 1'b0;
  endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench: config and status reads, power-save states, watchdog
`timescale 1ns/100ps
module tb_top;
  import wps_pkg::*;
  localparam logic [23:0] CFG_A [4] = '{OSC_CFG_ADDR, WDT_CFG_ADDR, BRN_CFG_ADDR, PROT_CFG_ADDR};
  logic core_clk = 1'b0, rst_b = 1'b0, external_pin_reset_b = 1'b1, irq_wake = 1'b0, lvd_enable = 1'b0;
  logic low_power_rc_clock = 1'b0, nv_erased = 1'b0, tbl_rd = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic low_power_rc_clock_run = 1'b0, pend_s = 1'b0, pend_t = 1'b0, rst_d = 1'b0, por_req = 1'b0, osc_done = 1'b1;
  logic [23:0] tbl_addr = '0, tbl_rdata, exp_q[$];
  logic [15:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, cfg_v[4];
  logic [1:0] current_osc_source = OSC_FAST_RC, active_osc_source;
  logic watchdog_clear_instruction, power_save_instruction, power_save_operand;
  logic cpu_clk_en, periph_clk_en, osc_en, clk_mon_active, brownout_active, lvd_active;
  logic sys_reset, wake_pulse, wake_to_isr, low_power_rc_clock_en, clk_fail_trap;
  wps_state_t power_state;
  int error_cnt = 0, checked = 0, rst_cnt = 0, n;
  logic [31:0] seed = 32'h8268;
  wps_core #(.WDT_W(4)) wps_core_inst (.core_clk, .rst_b, .external_pin_reset_b, .poweron_reset_req(por_req),
    .brownout_reset_req(1'b0), .low_power_rc_clock, .watchdog_clear_instruction, .power_save_instruction,
    .power_save_operand, .irq_wake, .current_osc_source, .low_power_crystal_keep(1'b0),
    .oscillator_startup_timer_done(osc_done), .pll_lock_flag(1'b1), .lvd_enable, .nv_erased,
    .osc_cfg_fuses(cfg_v[0]), .wdt_cfg_fuses(cfg_v[1]), .brn_cfg_fuses(cfg_v[2]), .prot_cfg_fuses(cfg_v[3]),
    .tbl_rd, .tbl_addr, .tbl_rdata, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .cpu_clk_en,
    .periph_clk_en, .osc_en, .clk_mon_active, .low_power_rc_clock_en, .brownout_active, .lvd_active, .active_osc_source,
    .sys_reset, .wake_pulse, .wake_to_isr, .clk_fail_trap, .power_state);
  wps_cpu_model wps_cpu_model_inst (.core_clk, .watchdog_clear_instruction, .power_save_instruction,
    .power_save_operand);
  // clock and slow rc clock (toggles only while enabled)
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (low_power_rc_clock_run) low_power_rc_clock <= ~low_power_rc_clock;
  // xorshift random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // register access; a read notes its expected word
  task automatic sfr(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge core_clk);
    sfr_wr <= wr;
    sfr_rd <= ~wr;
    sfr_addr <= a;
    sfr_wdata <= d;
    if (!wr) exp_q.push_back({8'h00, e});
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
  endtask
  task automatic tbl(input logic [23:0] a, input logic [23:0] e);
    @(posedge core_clk);
    tbl_rd <= 1'b1;
    tbl_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    tbl_rd <= 1'b0;
  endtask
  // watcher: read data lands one cycle after the read edge
  always @(posedge core_clk) begin
    pend_s <= sfr_rd;
    pend_t <= tbl_rd;
    rst_d <= sys_reset;
    if (sys_reset === 1'b1 && rst_d !== 1'b1) rst_cnt++; // a held reset counts once
    if (pend_s) chk("sfr_rdata", exp_q.pop_front(), {8'h00, sfr_rdata});
    if (pend_t) chk("tbl_rdata", exp_q.pop_front(), tbl_rdata);
  end
  // bounded wait for a power state, counting falling edges
  task automatic wait_st(input wps_state_t s, output int k);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (power_state !== s && k < 2000);
    if (k >= 2000) chk("power_state", 24'(s), 24'(power_state));
  endtask
  task automatic report_and_stop();
    $display("checks %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    // random fuses: clock switching on, monitor off, fast rc source, watchdog fuse off
    foreach (cfg_v[i]) begin
      seed = xs(seed);
      cfg_v[i] = seed[15:0];
    end
    cfg_v[0] = (cfg_v[0] & 16'h3CFF) | 16'h8100;
    cfg_v[1][WDT_FUSE_EN_BIT] = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, RC_RESET_VAL);
    foreach (CFG_A[i]) tbl(CFG_A[i], {8'h00, cfg_v[i]});
    tbl(24'hF80006, 24'h000000);
    sfr(1'b0, 16'h0742, 16'h0000, 16'h0000);
    nv_erased <= 1'b1;
    tbl(WDT_CFG_ADDR, {8'h00, CFG_ERASED});
    nv_erased <= 1'b0;
    // idle, interrupt wake with no delay
    sfr(1'b1, RSTCTL_ADDR, 16'h0000, 16'h0000);
    wps_cpu_model_inst.exec_save(PS_IDLE);
    wait_st(ST_IDLE, n);
    chk("idle gates", 24'({cpu_clk_en, periph_clk_en, osc_en}), 24'h3);
    @(posedge core_clk) irq_wake <= 1'b1;
    wait_st(ST_RUN, n);
    chk("idle wake cycles", 24'(n), 24'd2);
    chk("idle wake pulses", 24'({wake_pulse, wake_to_isr}), 24'h3);
    @(posedge core_clk) irq_wake <= 1'b0;
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, 16'h0004);
    // pin reset during idle
    sfr(1'b1, RSTCTL_ADDR, 16'h0000, 16'h0000);
    wps_cpu_model_inst.exec_save(PS_IDLE);
    wait_st(ST_IDLE, n);
    @(posedge core_clk) external_pin_reset_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    external_pin_reset_b <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("reset ends idle", 24'({power_state, cpu_clk_en}), 24'({ST_RUN, 1'b1}));
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, 16'h0084);
    // deep sleep, interrupt wake after power-on delay
    sfr(1'b1, RSTCTL_ADDR, 16'h0000, 16'h0000);
    lvd_enable <= 1'b1;
    wps_cpu_model_inst.exec_save(PS_SLEEP);
    wait_st(ST_SLEEP, n);
    chk("sleep gates", 24'({cpu_clk_en, periph_clk_en, osc_en, clk_mon_active, low_power_rc_clock_en}), 24'h0);
    chk("detectors", 24'({brownout_active, lvd_active}), 24'({cfg_v[2][BRN_EN_BIT], 1'b1}));
    @(posedge core_clk) irq_wake <= 1'b1;
    wait_st(ST_WAKE, n);
    @(posedge core_clk) irq_wake <= 1'b0;
    wait_st(ST_RUN, n);
    // count starts one edge into wake, which spans the delay plus its end compare
    chk("sleep wake cycles", 24'(n), 24'(POWER_ON_DELAY_CYC + 1));
    chk("wake source", 24'({wake_to_isr, active_osc_source}), 24'({1'b1, OSC_FAST_RC}));
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, 16'h0008);
    // fuse-enabled watchdog: clears hold it off, then it resets the device
    sfr(1'b1, RSTCTL_ADDR, 16'h0000, 16'h0000);
    cfg_v[1][WDT_FUSE_EN_BIT] <= 1'b1;
    low_power_rc_clock_run <= 1'b1;
    repeat (30) wps_cpu_model_inst.exec_clear();
    chk("reset count", 24'(rst_cnt), 24'd1);
    for (n = 0; n < 300 && rst_cnt == 1; n++) @(posedge core_clk);
    cfg_v[1][WDT_FUSE_EN_BIT] <= 1'b0;
    low_power_rc_clock_run <= 1'b0;
    chk("reset count", 24'(rst_cnt), 24'd2);
    repeat (4) @(posedge core_clk);
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, 16'h0010);
    // software-enabled watchdog wakes deep sleep instead of resetting
    sfr(1'b1, RSTCTL_ADDR, 16'h0020, 16'h0000);
    low_power_rc_clock_run <= 1'b1;
    wps_cpu_model_inst.exec_clear();
    wps_cpu_model_inst.exec_save(PS_SLEEP);
    wait_st(ST_WAKE, n);
    @(posedge core_clk) low_power_rc_clock_run <= 1'b0;
    wait_st(ST_RUN, n);
    chk("reset count", 24'(rst_cnt), 24'd2);
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, 16'h0038);
    // crystal wake with a dead clock and the monitor on: trap to fast rc
    cfg_v[0] <= (cfg_v[0] & 16'hFCF3) | 16'hC304;
    current_osc_source <= OSC_PRIMARY;
    osc_done <= 1'b0;
    wps_cpu_model_inst.exec_save(PS_SLEEP);
    wait_st(ST_SLEEP, n);
    @(posedge core_clk) irq_wake <= 1'b1;
    wait_st(ST_WAKE, n);
    @(posedge core_clk) irq_wake <= 1'b0;
    wait_st(ST_RUN, n);
    chk("crystal wake cycles", 24'(n), 24'(POWER_ON_DELAY_CYC + POWERUP_TIMER_CYC + 1));
    chk("clock trap", 24'({clk_fail_trap, active_osc_source}), 24'({1'b1, OSC_FAST_RC}));
    // power-on event restores the reset control word
    @(posedge core_clk) por_req <= 1'b1;
    @(posedge core_clk) por_req <= 1'b0;
    sfr(1'b0, RSTCTL_ADDR, 16'h0000, RC_RESET_VAL);
    chk("reset count", 24'(rst_cnt), 24'd3);
    repeat (3) @(posedge core_clk);
    report_and_stop();
  end
endmodule
